/* logic/acb_bus_port.v */
// async cpu bus port: apb registers drive one external bus cycle at a time
// assumes all bus pins are outside pclk's domain; three-state pins resolved outside
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acb_regs.vh"

module acb_bus_port #(
   parameter RST_DRIVE = `ACB_RST_DRIVE
) (
   input wire pclk,
   input wire presetn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output wire [22:0] address_lines,
   output wire address_lines_oe,
   input wire [15:0] data_lines_in,
   output wire [15:0] data_lines_out,
   output wire data_lines_oe,
   output wire addr_strobe_n,
   output wire upper_byte_strobe_n,
   output wire lower_byte_strobe_n,
   output wire read_not_write,
   output wire control_oe,
   input wire transfer_ack_n,
   input wire bus_claim_request_n,
   output wire bus_claim_grant_n,
   input wire bus_claim_taken_n,
   input wire [2:0] int_level_in_n,
   input wire cycle_fault_in_n,
   input wire reset_line_in_n,
   output wire reset_line_out,
   output wire reset_line_oe,
   input wire halt_line_in_n,
   output wire halt_line_out,
   output wire halt_line_oe,
   output wire periph_enable,
   input wire sync_device_select_n,
   output wire sync_addr_valid_n,
   output wire [2:0] cycle_kind_code,
   output wire cycle_kind_oe
);
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam S_IDLE = 3'd0;
   localparam S_ADDR = 3'd1;
   localparam S_STRB = 3'd2;
   localparam S_WAIT = 3'd3;
   localparam S_SYNC = 3'd4;
   localparam S_RMW = 3'd5;
   localparam S_END = 3'd6;
   localparam S_RETRY = 3'd7;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // returns {upper, lower} strobe enables, active high
   function [1:0] lane_sel;
      input is_byte;
      input a0;
      begin
         if (!is_byte)
            lane_sel = 2'b11;
         else if (a0)
            lane_sel = 2'b01;
         else
            lane_sel = 2'b10;
      end
   endfunction

   // byte reads land right-justified
   function [15:0] lane_read;
      input is_byte;
      input a0;
      input [15:0] d;
      begin
         if (!is_byte)
            lane_read = d;
         else if (a0)
            lane_read = {8'h00, d[7:0]};
         else
            lane_read = {8'h00, d[15:8]};
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   wire [25:0] pins_s;
   acb_sync #(.W(26)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({sync_device_select_n, halt_line_in_n, reset_line_in_n, cycle_fault_in_n,
               int_level_in_n, bus_claim_taken_n, bus_claim_request_n, transfer_ack_n,
               data_lines_in}),
      .pin_sync(pins_s)
   );
   wire [15:0] din_s = pins_s[15:0];
   wire ack_s = ~pins_s[16];
   wire req_s = ~pins_s[17];
   wire taken_s = ~pins_s[18];
   wire [2:0] lvl_s = ~pins_s[21:19];
   wire fault_s = ~pins_s[22];
   wire rst_s = ~pins_s[23];
   wire halt_s = ~pins_s[24];
   wire vpa_s = ~pins_s[25];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [2:0] state_q;
   reg [23:0] addr_reg_q;
   reg [15:0] wdata_q;
   reg [15:0] rdata_q;
   reg [2:0] mask_q;
   reg [8:0] cmd_q;
   reg [8:0] cur_q;
   reg req_q;
   reg [22:0] addr_q;
   reg [15:0] dout_q;
   reg aoe_q;
   reg doe_q;
   reg as_q;
   reg [1:0] strb_q;
   reg rw_q;
   reg vma_q;
   reg [2:0] fc_q;
   reg done_q;
   reg fault_q;
   reg auto_q;
   reg stop_q;
   reg rst_seen_q;
   reg total_q;
   reg grant_q;
   reg [7:0] rst_cnt_q;
   reg [1:0] own_rst_q;
   reg [3:0] e_cnt_q;
   reg e_q;

   // ----------------------------------------------------------------
   // apb access
   // ----------------------------------------------------------------
   wire wr = psel & penable & pwrite;
   wire mapped = (paddr == `ACB_OFF_CTRL) | (paddr == `ACB_OFF_ADDR) |
                 (paddr == `ACB_OFF_WDATA) | (paddr == `ACB_OFF_RDATA) |
                 (paddr == `ACB_OFF_STATUS) | (paddr == `ACB_OFF_MASK);
   wire wr_ctrl = wr & (paddr == `ACB_OFF_CTRL);
   wire wr_stat = wr & (paddr == `ACB_OFF_STATUS);
   wire start_wr = wr_ctrl & pwdata[`ACB_CTRL_START];
   wire rstcmd_wr = wr_ctrl & pwdata[`ACB_CTRL_RSTCMD];
   wire stopcmd_wr = wr_ctrl & pwdata[`ACB_CTRL_STOPCMD];

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg_q <= 24'h000000;
         wdata_q <= 16'h0000;
         mask_q <= `ACB_MASK_RST;
         cmd_q <= 9'h000;
      end else if (wr) begin
         case (paddr)
            `ACB_OFF_CTRL: cmd_q <= pwdata[8:0];
            `ACB_OFF_ADDR: addr_reg_q <= pwdata[23:0];
            `ACB_OFF_WDATA: wdata_q <= pwdata[15:0];
            `ACB_OFF_MASK: mask_q <= pwdata[2:0];
            default: cmd_q <= cmd_q;
         endcase
      end
   end

   wire int_pend = (lvl_s == 3'h7) | (lvl_s > mask_q);
   wire busy = req_q | (state_q != S_IDLE);
   wire halt_ext = halt_s & ~stop_q;
   wire halted = halt_ext & (state_q == S_IDLE);
   wire released = taken_s & (state_q == S_IDLE);

   always @* begin
      prdata = 32'h00000000;
      case (paddr)
         `ACB_OFF_CTRL: prdata = {23'h000000, cmd_q};
         `ACB_OFF_ADDR: prdata = {8'h00, addr_reg_q};
         `ACB_OFF_WDATA: prdata = {16'h0000, wdata_q};
         `ACB_OFF_RDATA: prdata = {16'h0000, rdata_q};
         `ACB_OFF_MASK: prdata = {29'h00000000, mask_q};
         `ACB_OFF_STATUS: begin
            prdata[`ACB_ST_BUSY] = busy;
            prdata[`ACB_ST_DONE] = done_q;
            prdata[`ACB_ST_FAULT] = fault_q;
            prdata[`ACB_ST_AUTOVEC] = auto_q;
            prdata[`ACB_ST_HALTED] = halted;
            prdata[`ACB_ST_RELEASED] = released;
            prdata[`ACB_ST_STOPPED] = stop_q;
            prdata[`ACB_ST_RSTSEEN] = rst_seen_q;
            prdata[10:8] = lvl_s;
            prdata[`ACB_ST_PEND] = int_pend;
            prdata[`ACB_ST_TOTAL] = total_q;
         end
         default: prdata = 32'h00000000;
      endcase
   end

   // ----------------------------------------------------------------
   // reset line, halt line, arbitration
   // ----------------------------------------------------------------
   // own drive echoes back through the synchroniser two cycles late
   wire rst_drv = (rst_cnt_q != 8'h00);
   wire ext_rst = rst_s & ~rst_drv & ~own_rst_q[0] & ~own_rst_q[1];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_q <= 8'h00;
         own_rst_q <= 2'b00;
         grant_q <= 1'b0;
      end else begin
         own_rst_q <= {own_rst_q[0], rst_drv};
         if (rstcmd_wr && !rst_drv)
            rst_cnt_q <= RST_DRIVE[7:0];
         else if (rst_drv)
            rst_cnt_q <= rst_cnt_q - 8'h01;
         grant_q <= req_s & ~taken_s;
      end
   end

   assign reset_line_out = 1'b0;
   assign reset_line_oe = rst_drv;
   assign halt_line_out = 1'b0;
   assign halt_line_oe = stop_q;
   assign bus_claim_grant_n = ~grant_q;

   // ----------------------------------------------------------------
   // enable clock
   // ----------------------------------------------------------------
   // ten-count ring
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e_cnt_q <= 4'h0;
         e_q <= 1'b0;
      end else begin
         e_cnt_q <= (e_cnt_q == `ACB_E_PERIOD - 4'h1) ? 4'h0 : e_cnt_q + 4'h1;
         e_q <= (e_cnt_q >= `ACB_E_LOW - 4'h1) && (e_cnt_q != `ACB_E_PERIOD - 4'h1);
      end
   end
   assign periph_enable = e_q;
   wire e_last = (e_cnt_q == `ACB_E_PERIOD - 4'h1);

   // ----------------------------------------------------------------
   // bus cycle engine
   // ----------------------------------------------------------------
   wire cur_rd = cur_q[`ACB_CTRL_READ];
   wire cur_byte = cur_q[`ACB_CTRL_BYTE];
   wire cur_rmw = cur_q[`ACB_CTRL_RMW];
   wire cur_iack = cur_q[`ACB_CTRL_IACK];
   wire a0 = addr_reg_q[0];
   // reads first phase of rmw too; write-back follows
   wire more = cur_rmw & rw_q;
   wire [2:0] next_after = more ? S_RMW : S_END;
   wire can_start = req_q & ~halt_ext & ~taken_s & ~stop_q & ~grant_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         cur_q <= 9'h000;
         req_q <= 1'b0;
         addr_q <= 23'h000000;
         dout_q <= 16'h0000;
         rdata_q <= 16'h0000;
         aoe_q <= 1'b0;
         doe_q <= 1'b0;
         as_q <= 1'b0;
         strb_q <= 2'b00;
         rw_q <= 1'b1;
         vma_q <= 1'b0;
         fc_q <= 3'h0;
         done_q <= 1'b0;
         fault_q <= 1'b0;
         auto_q <= 1'b0;
         stop_q <= 1'b0;
         rst_seen_q <= 1'b0;
         total_q <= 1'b0;
      end else if (ext_rst) begin
         state_q <= S_IDLE;
         req_q <= 1'b0;
         aoe_q <= 1'b0;
         doe_q <= 1'b0;
         as_q <= 1'b0;
         strb_q <= 2'b00;
         rw_q <= 1'b1;
         vma_q <= 1'b0;
         stop_q <= 1'b0;
         rst_seen_q <= 1'b1;
         total_q <= halt_s;
      end else begin
         // software clears first so a same-cycle event still sets
         if (wr_stat && pwdata[`ACB_ST_DONE])
            done_q <= 1'b0;
         if (wr_stat && pwdata[`ACB_ST_FAULT])
            fault_q <= 1'b0;
         if (wr_stat && pwdata[`ACB_ST_AUTOVEC])
            auto_q <= 1'b0;
         if (wr_stat && pwdata[`ACB_ST_RSTSEEN]) begin
            rst_seen_q <= 1'b0;
            total_q <= 1'b0;
         end
         if (stopcmd_wr)
            stop_q <= 1'b1;
         if (start_wr)
            req_q <= 1'b1;
         case (state_q)
            S_IDLE: begin
               // halt and handover only between cycles
               if (can_start) begin
                  req_q <= 1'b0;
                  cur_q <= cmd_q;
                  aoe_q <= 1'b1;
                  rw_q <= cmd_q[`ACB_CTRL_READ] | cmd_q[`ACB_CTRL_RMW] |
                          cmd_q[`ACB_CTRL_IACK];
                  if (cmd_q[`ACB_CTRL_IACK]) begin
                     addr_q <= {20'hfffff, lvl_s};
                     fc_q <= `ACB_FC_IACK;
                  end else begin
                     addr_q <= addr_reg_q[23:1];
                     fc_q <= {cmd_q[`ACB_CTRL_SUPER], cmd_q[`ACB_CTRL_PROG],
                              ~cmd_q[`ACB_CTRL_PROG]};
                  end
                  state_q <= S_ADDR;
               end
            end
            S_ADDR: begin
               as_q <= 1'b1;
               dout_q <= cur_byte ? {wdata_q[7:0], wdata_q[7:0]} : wdata_q;
               doe_q <= ~rw_q;
               state_q <= S_STRB;
            end
            S_STRB: begin
               strb_q <= cur_iack ? 2'b01 : lane_sel(cur_byte, a0);
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (ack_s) begin
                  if (rw_q)
                     rdata_q <= cur_iack ? {8'h00, din_s[7:0]} :
                                lane_read(cur_byte, a0, din_s);
                  state_q <= next_after;
               end else if (fault_s) begin
                  if (halt_s) begin
                     as_q <= 1'b0;
                     strb_q <= 2'b00;
                     state_q <= S_RETRY;
                  end else begin
                     if (fault_q)
                        stop_q <= 1'b1;
                     fault_q <= 1'b1;
                     state_q <= S_END;
                  end
               end else if (vpa_s) begin
                  if (cur_iack) begin
                     auto_q <= 1'b1;
                     state_q <= S_END;
                  end else begin
                     state_q <= S_SYNC;
                  end
               end
            end
            S_SYNC: begin
               if (e_last && !vma_q) begin
                  vma_q <= 1'b1;
               end else if (e_last && vma_q) begin
                  vma_q <= 1'b0;
                  if (rw_q)
                     rdata_q <= lane_read(cur_byte, a0, din_s);
                  state_q <= next_after;
               end
            end
            S_RMW: begin
               strb_q <= 2'b00;
               rw_q <= 1'b0;
               // synced answer of the read phase lingers; write-back waits until it clears
               if (!ack_s && !vpa_s)
                  state_q <= S_ADDR;
            end
            S_RETRY: begin
               if (!halt_s && !fault_s)
                  state_q <= S_ADDR;
            end
            S_END: begin
               as_q <= 1'b0;
               strb_q <= 2'b00;
               vma_q <= 1'b0;
               aoe_q <= 1'b0;
               doe_q <= 1'b0;
               rw_q <= 1'b1;
               done_q <= 1'b1;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // released bus floats controls
   wire ctl_on = ~released;
   assign address_lines = addr_q;
   assign address_lines_oe = aoe_q;
   assign data_lines_out = dout_q;
   assign data_lines_oe = doe_q;
   assign addr_strobe_n = ~as_q;
   assign upper_byte_strobe_n = ~strb_q[1];
   assign lower_byte_strobe_n = ~strb_q[0];
   assign read_not_write = rw_q;
   assign control_oe = ctl_on;
   assign sync_addr_valid_n = ~vma_q;
   assign cycle_kind_code = fc_q;
   assign cycle_kind_oe = aoe_q;
endmodule // acb_bus_port

`default_nettype wire

/* logic/acb_regs.vh */
// register offsets, field positions and timing counts for the async cpu bus port
// assumes a 32-bit apb slave decoding byte addresses on an 8-bit offset
`ifndef ACB_REGS_VH
`define ACB_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACB_OFF_CTRL 8'h00
`define ACB_OFF_ADDR 8'h04
`define ACB_OFF_WDATA 8'h08
`define ACB_OFF_RDATA 8'h0c
`define ACB_OFF_STATUS 8'h10
`define ACB_OFF_MASK 8'h14

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ACB_CTRL_START 0
`define ACB_CTRL_READ 1
`define ACB_CTRL_BYTE 2
`define ACB_CTRL_RMW 3
`define ACB_CTRL_SUPER 4
`define ACB_CTRL_PROG 5
`define ACB_CTRL_IACK 6
`define ACB_CTRL_RSTCMD 7
`define ACB_CTRL_STOPCMD 8

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ACB_ST_BUSY 0
`define ACB_ST_DONE 1
`define ACB_ST_FAULT 2
`define ACB_ST_AUTOVEC 3
`define ACB_ST_HALTED 4
`define ACB_ST_RELEASED 5
`define ACB_ST_STOPPED 6
`define ACB_ST_RSTSEEN 7
`define ACB_ST_LVL_LO 8
`define ACB_ST_PEND 11
`define ACB_ST_TOTAL 12

// ----------------------------------------------------------------
// reset values, codes and timing counts
// ----------------------------------------------------------------
`define ACB_MASK_RST 3'h0
`define ACB_FC_IACK 3'h7
`define ACB_E_PERIOD 4'ha
`define ACB_E_LOW 4'h6
`define ACB_RST_DRIVE 8'h7c

`endif

/* logic/acb_sync.v */
// two-flop synchroniser for a group of pin inputs
// assumes the pins are idle high (active low) at reset
`timescale 1ns/1ps
`default_nettype none

module acb_sync #(
   parameter W = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] pin_in,
   output wire [W-1:0] pin_sync
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign pin_sync = sync_q;
endmodule // acb_sync

`default_nettype wire

/* sim/acb_bus_port_monitor.sv */
// pin-level checker bound to every acb_bus_port instance
// assumes pin inputs pass two synchroniser edges before the engine sees them
`timescale 1ns/1ps
`default_nettype none
module acb_bus_port_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [22:0] address_lines,
   input wire logic address_lines_oe,
   input wire logic [15:0] data_lines_out,
   input wire logic data_lines_oe,
   input wire logic addr_strobe_n,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic read_not_write,
   input wire logic transfer_ack_n,
   input wire logic bus_claim_request_n,
   input wire logic bus_claim_grant_n,
   input wire logic bus_claim_taken_n,
   input wire logic cycle_fault_in_n,
   input wire logic reset_line_in_n,
   input wire logic periph_enable,
   input wire logic sync_device_select_n,
   input wire logic sync_addr_valid_n,
   input wire logic [2:0] cycle_kind_code
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire lanes_on = !(upper_byte_strobe_n && lower_byte_strobe_n);
   sequence s_en_high; periph_enable [*4]; endsequence
   sequence s_en_low; !periph_enable [*6]; endsequence
   sequence s_no_answer;
      (!addr_strobe_n && transfer_ack_n && cycle_fault_in_n && sync_device_select_n
         && reset_line_in_n) [*3];
   endsequence
   a_ack_addr_high: assert property (!addr_strobe_n && cycle_kind_code == 3'h7
      |-> &address_lines[22:3]) else $error("acknowledge address not all ones");
   a_strobe_addr_on: assert property (!addr_strobe_n |-> address_lines_oe)
      else $error("address strobe without driven address");
   a_write_dir_low: assert property (data_lines_oe |-> !read_not_write)
      else $error("data driven while direction reads");
   a_byte_dup_lanes: assert property (data_lines_oe && (upper_byte_strobe_n ^ lower_byte_strobe_n)
      |-> data_lines_out[15:8] == data_lines_out[7:0]) else $error("byte write not copied");
   a_ack_ends_cycle: assert property ($fell(transfer_ack_n) && lanes_on
      |-> ##[2:6] !lanes_on) else $error("strobes held after acknowledge");
   a_grant_on_req: assert property ((!bus_claim_request_n && bus_claim_taken_n) [*4]
      |-> !bus_claim_grant_n) else $error("request not granted");
   a_enable_shape: assert property ($rose(periph_enable)
      |-> s_en_high ##1 s_en_low ##1 periph_enable) else $error("enable period wrong");
   a_vma_from_sel: assert property ($fell(sync_addr_valid_n)
      |-> $past(sync_device_select_n, 2) == 1'b0) else $error("valid address without select");
   a_code_steady: assert property (!addr_strobe_n && !$past(addr_strobe_n)
      |-> $stable(cycle_kind_code)) else $error("cycle code moved under strobe");
   a_wait_no_ans: assert property (s_no_answer |=> !addr_strobe_n)
      else $error("cycle ended without an answer");
endmodule // acb_bus_port_monitor
bind acb_bus_port acb_bus_port_monitor acb_bus_port_monitor_i (.pclk(pclk), .presetn(presetn),
   .address_lines(address_lines), .address_lines_oe(address_lines_oe),
   .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
   .addr_strobe_n(addr_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
   .lower_byte_strobe_n(lower_byte_strobe_n), .read_not_write(read_not_write),
   .transfer_ack_n(transfer_ack_n), .bus_claim_request_n(bus_claim_request_n),
   .bus_claim_grant_n(bus_claim_grant_n), .bus_claim_taken_n(bus_claim_taken_n),
   .cycle_fault_in_n(cycle_fault_in_n), .reset_line_in_n(reset_line_in_n),
   .periph_enable(periph_enable), .sync_device_select_n(sync_device_select_n),
   .sync_addr_valid_n(sync_addr_valid_n), .cycle_kind_code(cycle_kind_code));
`default_nettype wire

/* sim/acb_bus_port_tb.sv */
// self-checking bench: random apb-driven bus cycles against the slave model
// assumes 10 MHz pclk and pull-ups on the open-drain reset and halt wires
`timescale 1ns/1ps
`default_nettype none
`include "acb_regs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD %0t %h %h", $time, (a), (b)); end end
module acb_bus_port_tb;
   logic pclk, presetn, psel, penable, pwrite, fault_n, req_n, taken_n, use_sync, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, r, st;
   logic [2:0] lvl_n;
   logic [3:0] delay;
   int fail_count = 0, n_compared = 0;
   wire [31:0] prdata;
   wire [22:0] address_lines;
   wire [15:0] din, dout, got_data;
   wire [2:0] code;
   wire [1:0] got_lanes;
   wire pready, as_n, uds_n, lds_n, rnw, ack_n, grant_n, rst_oe, halt_oe, sel_n, err_w;
   acb_bus_port #(.RST_DRIVE(8'h04)) acb_bus_port_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(err_w), .address_lines(address_lines),
      .address_lines_oe(), .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(),
      .addr_strobe_n(as_n), .upper_byte_strobe_n(uds_n), .lower_byte_strobe_n(lds_n),
      .read_not_write(rnw), .control_oe(), .transfer_ack_n(ack_n),
      .bus_claim_request_n(req_n), .bus_claim_grant_n(grant_n), .bus_claim_taken_n(taken_n),
      .int_level_in_n(lvl_n), .cycle_fault_in_n(fault_n), .reset_line_in_n(!rst_oe),
      .reset_line_out(), .reset_line_oe(rst_oe), .halt_line_in_n(!halt_oe),
      .halt_line_out(), .halt_line_oe(halt_oe), .periph_enable(), .sync_device_select_n(sel_n),
      .sync_addr_valid_n(), .cycle_kind_code(code), .cycle_kind_oe());
   acb_slave_model acb_slave_model_i (.pclk(pclk), .address_lines(address_lines),
      .data_lines_out(dout), .upper_byte_strobe_n(uds_n), .lower_byte_strobe_n(lds_n),
      .read_not_write(rnw), .delay(delay), .use_sync(use_sync), .transfer_ack_n(ack_n),
      .sync_device_select_n(sel_n), .data_lines_in(din), .got_data(got_data),
      .got_lanes(got_lanes));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task results();
      if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      err = err_w;
      if (k >= 50) begin fail_count++; results(); end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task op(input logic [23:0] a, input logic [8:0] c, input logic [15:0] d);
      int k;
      bus(1'b1, `ACB_OFF_ADDR, {8'h00, a});
      bus(1'b1, `ACB_OFF_WDATA, {16'h0000, d});
      bus(1'b1, `ACB_OFF_CTRL, {23'h000000, c});
      k = 0;
      do begin bus(1'b0, `ACB_OFF_STATUS, 32'h0); k++; end while (r[1] !== 1'b1 && k < 300);
      st = r;
      if (k >= 300) begin fail_count++; results(); end
      bus(1'b1, `ACB_OFF_STATUS, 32'h0000000e);
      bus(1'b0, `ACB_OFF_RDATA, 32'h0);
   endtask
   function logic [15:0] exp_rd(input logic [23:0] a, input logic b);
      logic [15:0] w;
      w = a[16:1] ^ 16'h5a5a;
      if (!b) return w;
      return a[0] ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
   endfunction
   initial begin
      logic [23:0] a;
      logic [15:0] d;
      logic b, rd, s, p;
      int n;
      {psel, penable, pwrite, presetn, use_sync, req_n, taken_n, fault_n} = 8'h0f;
      paddr = 8'h00;
      pwdata = 32'h0;
      lvl_n = 3'h7;
      delay = 4'h0;
      void'($urandom(32'h2e01));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, `ACB_OFF_MASK, 32'h0);
      `CHK(r[2:0], `ACB_MASK_RST)
      // unmapped offset is refused
      bus(1'b1, 8'h3c, 32'h0);
      `CHK(err, 1'b1)
      // every fourth cycle goes through the sync select path
      for (int i = 0; i < 16; i++) begin
         a = 24'($urandom);
         d = 16'($urandom);
         b = 1'($urandom);
         rd = 1'($urandom);
         s = 1'($urandom);
         p = 1'($urandom);
         delay <= (i == 1) ? 4'hf : 4'($urandom);
         use_sync <= (i % 4 == 3);
         op(a, {3'h0, p, s, 1'b0, b, rd, 1'b1}, d);
         `CHK(code, {s, p, !p})
         `CHK(got_lanes, b ? {a[0], !a[0]} : 2'b00)
         if (rd) `CHK(r[15:0], exp_rd(a, b))
         else `CHK(got_data, b ? {d[7:0], d[7:0]} : d)
      end
      use_sync <= 1'b0;
      // read-modify-write byte at odd address writes back the copied byte
      op(24'h000101, 9'h00d, 16'h00c3);
      `CHK(got_data, 16'hc3c3)
      lvl_n <= ~3'h5;
      op(24'h0, 9'h041, 16'h0);
      `CHK(r[7:0], 8'ha7)
      `CHK(st[10:8], 3'h5)
      use_sync <= 1'b1;
      op(24'h0, 9'h041, 16'h0);
      `CHK(st[3], 1'b1)
      use_sync <= 1'b0;
      lvl_n <= 3'h7;
      // request on the shared line, grant follows synchroniser plus one
      req_n <= 1'b0;
      repeat (5) @(posedge pclk);
      `CHK(grant_n, 1'b0)
      // take the bus only with strobe and acknowledge idle
      taken_n <= 1'b0;
      @(posedge pclk);
      req_n <= 1'b1;
      repeat (5) @(posedge pclk);
      `CHK(grant_n, 1'b1)
      taken_n <= 1'b1;
      bus(1'b1, `ACB_OFF_CTRL, 32'h00000080);
      // first driven cycle already passed inside the bus task
      n = int'(rst_oe);
      repeat (20) begin @(posedge pclk); n += rst_oe; end
      `CHK(n, 4)
      bus(1'b0, `ACB_OFF_STATUS, 32'h0);
      `CHK(r[7], 1'b0)
      results();
   end
endmodule // acb_bus_port_tb
`default_nettype wire

/* sim/acb_slave_model.sv */
// far-side slave: memory or synchronous peripheral answering the port's cycles
// assumes active-low strobes; answers after delay cycles, held until strobes rise
`timescale 1ns/1ps
`default_nettype none
module acb_slave_model (
   input wire logic pclk,
   input wire logic [22:0] address_lines,
   input wire logic [15:0] data_lines_out,
   input wire logic upper_byte_strobe_n,
   input wire logic lower_byte_strobe_n,
   input wire logic read_not_write,
   input wire logic [3:0] delay,
   input wire logic use_sync,
   output logic transfer_ack_n,
   output logic sync_device_select_n,
   output logic [15:0] data_lines_in,
   output logic [15:0] got_data,
   output logic [1:0] got_lanes
);
   int k;
   initial begin
      transfer_ack_n = 1'b1;
      sync_device_select_n = 1'b1;
      data_lines_in = 16'h0000;
      got_data = 16'h0000;
      got_lanes = 2'h3;
      k = 0;
   end
   always @(posedge pclk) begin
      if (upper_byte_strobe_n && lower_byte_strobe_n) begin
         k <= 0;
         transfer_ack_n <= 1'b1;
         sync_device_select_n <= 1'b1;
         // released lanes toggle so no stale value reads as good data
         data_lines_in <= ~data_lines_in;
      end else if (k < delay) begin
         k <= k + 1;
      end else begin
         // answer by acknowledge or by sync select
         transfer_ack_n <= use_sync;
         sync_device_select_n <= !use_sync;
         // read word from address, vector lands in low lanes
         if (read_not_write) data_lines_in <= address_lines[15:0] ^ 16'h5a5a;
         else got_data <= data_lines_out;
         got_lanes <= {upper_byte_strobe_n, lower_byte_strobe_n};
      end
   end
endmodule // acb_slave_model
`default_nettype wire
